// file: rtl/e2s_pkg.sv
// constants and types of the two-wire serial eeprom slave
// assumes a 100 MHz core clock and an oversampling link clock
package e2s_pkg;

   // command byte decode
   localparam logic [3:0] CMD_NIBBLE   = 4'ha;
   localparam int         CMD_HI_LSB   = 1;

   // page geometry
   localparam int         PAGE_BYTES   = 16;
   localparam int         PAGE_W       = 4;
   localparam int         LOW_ADDR_W   = 8;
   localparam int         MEM_BYTES    = 2048;

   // bit slot counter marks
   localparam logic [3:0] SLOT_ACK     = 4'h8;
   localparam logic [3:0] SLOT_DONE    = 4'h9;
   localparam logic [3:0] SLOT_FIRST   = 4'h0;
   localparam logic [3:0] SLOT_ONE     = 4'h1;

   // erased cell contents
   localparam logic [7:0] ERASED       = 8'hff;

   // longest erase/write time, in whole core cycles
   localparam int         PROG_TIME_US = 8000;
   localparam int         CLK_MHZ      = 100;
   localparam int         PROG_CYCLES  = PROG_TIME_US * CLK_MHZ;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_CMD,
      ST_LADDR,
      ST_WDATA,
      ST_RDATA,
      ST_IGNORE
   } e2s_state_t;

   typedef enum logic [1:0] {
      PG_IDLE,
      PG_ERASE,
      PG_WRITE
   } e2s_prog_t;

endpackage

// file: rtl/e2s_two_wire_eeprom.sv
// slave protocol engine, page buffer, array and self-timed write of a two-wire eeprom
// assumes scl, sda and wp come straight from pins; sda is open drain with an external pull-up
`timescale 1ns/1ps

module e2s_two_wire_eeprom #(
   parameter int MEM_BYTES   = e2s_pkg::MEM_BYTES,
   parameter int PROG_CYCLES = e2s_pkg::PROG_CYCLES
) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic link_clk_i,
   input  wire logic scl_i,
   input  wire logic sda_i,
   input  wire logic wp_i,
   output wire logic sda_o,
   output wire logic sda_oe_o,
   output wire logic prog_busy_o
);

   localparam int ADDR_W = $clog2(MEM_BYTES);
   localparam int HI_W   = ADDR_W - e2s_pkg::LOW_ADDR_W;
   localparam int PAGE_N = MEM_BYTES / e2s_pkg::PAGE_BYTES;
   localparam int PG_A_W = ADDR_W - e2s_pkg::PAGE_W;
   localparam int TMR_W  = $clog2(PROG_CYCLES + 1);

   // ---------------- link domain ----------------
   logic                         scl_m, scl_s, scl_q;
   logic                         sda_m, sda_s, sda_q;
   logic                         wp_m, wp_s;
   logic                         start_c, stop_c, rise_c, fall_c;
   e2s_pkg::e2s_state_t          state;
   logic [3:0]                   cnt;
   logic [7:0]                   sh;
   logic [7:0]                   tx;
   logic [ADDR_W-1:0]            addr;
   logic [HI_W-1:0]              cmd_hi;
   logic [PG_A_W-1:0]            page;
   logic                         cmd_rd;
   logic                         mack;
   logic                         got_data;
   logic                         pull;
   logic [e2s_pkg::PAGE_BYTES-1:0] mask;
   logic [7:0]                   page_buf [e2s_pkg::PAGE_BYTES];
   logic [7:0]                   mem [MEM_BYTES];
   logic                         buf_we;
   logic                         launch;
   logic                         busy_l;
   logic                         req_tgl;
   logic                         done_m, done_s, done_q;
   logic                         done_ev;
   e2s_pkg::e2s_prog_t           pg;

   // ---------------- core domain ----------------
   logic                         req_m, req_s, req_q;
   logic [TMR_W-1:0]             tmr;
   logic                         busy_c;
   logic                         done_tgl;

   // pins pass two flops before anything looks at them
   always_ff @(posedge link_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_q <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_q <= 1'b1;
         wp_m  <= 1'b0;
         wp_s  <= 1'b0;
      end else begin
         scl_m <= scl_i;
         scl_s <= scl_m;
         scl_q <= scl_s;
         sda_m <= sda_i;
         sda_s <= sda_m;
         sda_q <= sda_s;
         wp_m  <= wp_i;
         wp_s  <= wp_m;
      end
   end

   assign start_c = scl_s && scl_q && sda_q && !sda_s;
   assign stop_c  = scl_s && scl_q && !sda_q && sda_s;
   assign rise_c  = scl_s && !scl_q;
   assign fall_c  = !scl_s && scl_q;

   // open drain: the pad only ever sinks
   assign sda_o    = 1'b0;
   assign sda_oe_o = pull;

   // programming starts only on stop after data, and never under protection
   assign launch = stop_c && (state == e2s_pkg::ST_WDATA) && got_data
                   && !wp_s && !busy_l;

   assign buf_we = fall_c && (cnt == e2s_pkg::SLOT_ACK) && (state == e2s_pkg::ST_WDATA);

   // protocol engine
   always_ff @(posedge link_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state    <= e2s_pkg::ST_IDLE;
         cnt      <= e2s_pkg::SLOT_FIRST;
         sh       <= '0;
         tx       <= '0;
         addr     <= '0;
         cmd_hi   <= '0;
         page     <= '0;
         cmd_rd   <= 1'b0;
         mack     <= 1'b0;
         got_data <= 1'b0;
         pull     <= 1'b0;
         mask     <= '0;
      end else if (start_c) begin
         // a repeated start drops pending data, address stays loaded
         state    <= e2s_pkg::ST_CMD;
         cnt      <= e2s_pkg::SLOT_FIRST;
         got_data <= 1'b0;
         pull     <= 1'b0;
      end else if (stop_c) begin
         state    <= e2s_pkg::ST_IDLE;
         got_data <= 1'b0;
         pull     <= 1'b0;
      end else begin
         case (state)
            e2s_pkg::ST_IDLE, e2s_pkg::ST_IGNORE: begin
               pull <= 1'b0;
            end
            default: begin
               if (rise_c) begin
                  if (cnt < e2s_pkg::SLOT_ACK) begin
                     sh  <= {sh[6:0], sda_s};
                     cnt <= cnt + 4'h1;
                  end else if (cnt == e2s_pkg::SLOT_ACK) begin
                     mack <= !sda_s;
                     cnt  <= e2s_pkg::SLOT_DONE;
                  end
               end else if (fall_c) begin
                  if (cnt == e2s_pkg::SLOT_ACK) begin
                     // eighth bit just ended: acknowledge slot opens
                     case (state)
                        e2s_pkg::ST_CMD: begin
                           if (sh[7:4] == e2s_pkg::CMD_NIBBLE && !busy_l) begin
                              pull   <= 1'b1;
                              cmd_rd <= sh[0];
                              if (!sh[0]) begin
                                 cmd_hi <= sh[e2s_pkg::CMD_HI_LSB +: HI_W];
                              end
                           end else begin
                              state <= e2s_pkg::ST_IGNORE;
                           end
                        end
                        e2s_pkg::ST_LADDR: begin
                           addr <= {cmd_hi, sh};
                           page <= PG_A_W'({cmd_hi, sh} >> e2s_pkg::PAGE_W);
                           mask <= '0;
                           pull <= 1'b1;
                        end
                        e2s_pkg::ST_WDATA: begin
                           // only the low nibble moves, so entry wraps in the page
                           addr[e2s_pkg::PAGE_W-1:0] <= addr[e2s_pkg::PAGE_W-1:0] + 4'h1;
                           mask[addr[e2s_pkg::PAGE_W-1:0]] <= 1'b1;
                           got_data <= 1'b1;
                           pull <= 1'b1;
                        end
                        default: begin
                           pull <= 1'b0;
                        end
                     endcase
                  end else if (cnt == e2s_pkg::SLOT_DONE) begin
                     cnt  <= e2s_pkg::SLOT_FIRST;
                     pull <= 1'b0;
                     case (state)
                        e2s_pkg::ST_CMD: begin
                           if (cmd_rd) begin
                              state <= e2s_pkg::ST_RDATA;
                              tx    <= mem[addr];
                              pull  <= !mem[addr][7];
                              addr  <= addr + 1'b1;
                           end else begin
                              state <= e2s_pkg::ST_LADDR;
                           end
                        end
                        e2s_pkg::ST_LADDR: begin
                           state <= e2s_pkg::ST_WDATA;
                        end
                        e2s_pkg::ST_RDATA: begin
                           if (mack) begin
                              tx   <= mem[addr];
                              pull <= !mem[addr][7];
                              addr <= addr + 1'b1;
                           end else begin
                              state <= e2s_pkg::ST_IGNORE;
                           end
                        end
                        default: begin
                           state <= state;
                        end
                     endcase
                  end else if (state == e2s_pkg::ST_RDATA && cnt >= e2s_pkg::SLOT_ONE) begin
                     tx   <= {tx[6:0], 1'b0};
                     pull <= !tx[6];
                  end
               end
            end
         endcase
      end
   end

   // page buffer holds entered bytes until the write step after the timer
   always_ff @(posedge link_clk_i) begin
      if (buf_we) begin
         page_buf[addr[e2s_pkg::PAGE_W-1:0]] <= sh;
      end
   end

   // done event from the core timer, toggle crossing
   always_ff @(posedge link_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         done_m <= 1'b0;
         done_s <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_m <= done_tgl;
         done_s <= done_m;
         done_q <= done_s;
      end
   end

   assign done_ev = done_s ^ done_q;

   // programming sequencer: launch, wait for timer, erase, write
   always_ff @(posedge link_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_l  <= 1'b0;
         req_tgl <= 1'b0;
         pg      <= e2s_pkg::PG_IDLE;
      end else begin
         case (pg)
            e2s_pkg::PG_IDLE: begin
               if (launch) begin
                  busy_l  <= 1'b1;
                  req_tgl <= !req_tgl;
               end else if (busy_l && done_ev) begin
                  pg <= e2s_pkg::PG_ERASE;
               end
            end
            e2s_pkg::PG_ERASE: begin
               pg <= e2s_pkg::PG_WRITE;
            end
            default: begin
               pg     <= e2s_pkg::PG_IDLE;
               busy_l <= 1'b0;
            end
         endcase
      end
   end

   // array: masked bytes erased to ones, then written from the buffer
   always_ff @(posedge link_clk_i) begin
      for (int i = 0; i < e2s_pkg::PAGE_BYTES; i++) begin
         if (mask[i] && pg == e2s_pkg::PG_ERASE) begin
            mem[{page, e2s_pkg::PAGE_W'(i)}] <= e2s_pkg::ERASED;
         end else if (mask[i] && pg == e2s_pkg::PG_WRITE) begin
            mem[{page, e2s_pkg::PAGE_W'(i)}] <= page_buf[i];
         end
      end
   end

   // ---------------- core domain: erase/write timer ----------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         req_m <= 1'b0;
         req_s <= 1'b0;
         req_q <= 1'b0;
      end else begin
         req_m <= req_tgl;
         req_s <= req_m;
         req_q <= req_s;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tmr      <= '0;
         busy_c   <= 1'b0;
         done_tgl <= 1'b0;
      end else if (!busy_c) begin
         if (req_s ^ req_q) begin
            busy_c <= 1'b1;
            tmr    <= TMR_W'(PROG_CYCLES - 1);
         end
      end else if (tmr == '0) begin
         busy_c   <= 1'b0;
         done_tgl <= !done_tgl;
      end else begin
         tmr <= tmr - 1'b1;
      end
   end

   assign prog_busy_o = busy_c;

   // keep page count visible to elaboration checks
   initial begin
      if (PAGE_N * e2s_pkg::PAGE_BYTES != MEM_BYTES) begin
         $error("memory size must be whole pages");
      end
   end

endmodule

// file: testbench/e2s_two_wire_eeprom_asserts.sv
// pin-level assertions of the two-wire eeprom slave
// assumes scl phases of at least six link clocks
`timescale 1ns/1ps
module e2s_two_wire_eeprom_asserts #(
   parameter int MEM_BYTES   = 2048,
   parameter int PROG_CYCLES = 50
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic link_clk_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic wp_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic prog_busy_o
);
   int busy_cnt;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_cnt <= 0;
      end else begin
         busy_cnt <= prog_busy_o ? busy_cnt + 1 : 0;
      end
   end
   a_sda_sink_only: assert property (@(posedge link_clk_i) disable iff (!rst_n_i) sda_o == 1'b0)
      else $error("sda driven high");
   a_oe_scl_low: assert property (@(posedge link_clk_i) disable iff (!rst_n_i) $changed(sda_oe_o) |-> !scl_i)
      else $error("sda changed with scl high");
   a_pull_holds: assert property (@(posedge link_clk_i) disable iff (!rst_n_i) $rose(sda_oe_o) |-> sda_oe_o [*8])
      else $error("pull shorter than a bit");
   a_release_holds: assert property (@(posedge link_clk_i) disable iff (!rst_n_i) $fell(sda_oe_o) |-> !sda_oe_o [*8])
      else $error("release shorter than a bit");
   a_busy_bus_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i) $rose(prog_busy_o) |-> scl_i && sda_i)
      else $error("programming began without stop");
   a_busy_no_wp: assert property (@(posedge clk_i) disable iff (!rst_n_i) $rose(prog_busy_o) |-> !wp_i)
      else $error("programming while protected");
   a_busy_no_ack: assert property (@(posedge clk_i) disable iff (!rst_n_i) prog_busy_o |-> !sda_oe_o)
      else $error("ack while programming");
   a_busy_time_max: assert property (@(posedge clk_i) disable iff (!rst_n_i) busy_cnt <= PROG_CYCLES + 64)
      else $error("programming too long");
endmodule

bind e2s_two_wire_eeprom e2s_two_wire_eeprom_asserts #(.MEM_BYTES(MEM_BYTES), .PROG_CYCLES(PROG_CYCLES)) u_chk (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i), .scl_i(scl_i), .sda_i(sda_i),
   .wp_i(wp_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .prog_busy_o(prog_busy_o));

// file: testbench/e2s_master_model.sv
// two-wire bus master model: makes scl, pulls sda low or releases it
// assumes a pull-up on sda; scl stands high between frames
`timescale 1ns/1ps
module e2s_master_model #(
   parameter int HALF_NS = 300
) (
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      pull_o
);
   initial begin
      scl_o = 1'b1;
      pull_o = 1'b0;
   end
   // data moves mid low phase, sampled mid high phase
   task automatic bit_x(input logic b, output logic r);
      #(HALF_NS/2) pull_o = !b;
      #(HALF_NS/2) scl_o = 1'b1;
      #(HALF_NS/2) r = sda_i;
      #(HALF_NS/2) scl_o = 1'b0;
   endtask
   task automatic start();
      #(HALF_NS/2) pull_o = 1'b0;
      #(HALF_NS/2) scl_o = 1'b1;
      #(HALF_NS) pull_o = 1'b1;
      #(HALF_NS) scl_o = 1'b0;
   endtask
   task automatic stop();
      #(HALF_NS/2) pull_o = 1'b1;
      #(HALF_NS/2) scl_o = 1'b1;
      #(HALF_NS) pull_o = 1'b0;
      #(HALF_NS);
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], r);
      end
      bit_x(1'b1, ack);
   endtask
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, d[i]);
      end
      bit_x(last, r);
   endtask
endmodule

// file: testbench/tb_top.sv
// self-checking bench of the two-wire eeprom slave driven by a master model
// assumes the checker binds itself to the design
`timescale 1ns/1ps
module tb_top;
   localparam int PROG = 2000;
   logic clk_i, rst_n_i, link_clk_i, wp_i;
   wire logic sda, scl, pull, sda_o, sda_oe_o, prog_busy_o;
   int        bad_count, cmp_count;
   assign sda = (sda_oe_o ? sda_o : 1'b1) & ~pull;
   e2s_two_wire_eeprom #(.MEM_BYTES(2048), .PROG_CYCLES(PROG)) uut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i), .scl_i(scl), .sda_i(sda),
      .wp_i(wp_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .prog_busy_o(prog_busy_o));
   e2s_master_model m (.sda_i(sda), .scl_o(scl), .pull_o(pull));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      link_clk_i = 1'b0;
      #7;
      forever #24 link_clk_i = ~link_clk_i;
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_busy(input logic lvl, input int n);
      int k;
      for (k = 0; k < n && prog_busy_o !== lvl; k++) begin
         @(posedge clk_i);
      end
      if (k == n) begin
         bad_count++;
         $display("MISMATCH t=%0t busy wait got=%h exp=%h", $time, prog_busy_o, lvl);
         test_done();
      end
   endtask
   task automatic prog();
      wait_busy(1'b1, 100);
      wait_busy(1'b0, PROG + 200);
      repeat (20) @(posedge clk_i);
   endtask
   task automatic snd(input logic [7:0] d, input logic nack);
      logic a;
      m.wbyte(d, a);
      chk({7'h00, a}, {7'h00, nack});
   endtask
   task automatic wr(input logic [10:0] a, input logic [7:0] d0, d1, input int n);
      m.start();
      snd({4'ha, a[10:8], 1'b0}, 1'b0);
      snd(a[7:0], 1'b0);
      snd(d0, 1'b0);
      if (n > 1) begin
         snd(d1, 1'b0);
      end
      m.stop();
   endtask
   task automatic rd(input logic [10:0] a, input logic [7:0] e0, e1, input int n);
      logic [7:0] d;
      m.start();
      snd({4'ha, a[10:8], 1'b0}, 1'b0);
      snd(a[7:0], 1'b0);
      m.start();
      snd(8'haf, 1'b0);
      m.rbyte(n == 1, d);
      chk(d, e0);
      if (n > 1) begin
         m.rbyte(1'b1, d);
         chk(d, e1);
      end
      m.stop();
   endtask
   task automatic t_byte_write();
      wr(11'h511, 8'h5a, 8'h00, 1);
      wait_busy(1'b1, 100);
      chk({7'h00, prog_busy_o}, 8'h01);
      m.start();
      snd(8'ha0, 1'b1);
      m.stop();
      wait_busy(1'b0, PROG + 200);
      repeat (20) @(posedge clk_i);
      rd(11'h511, 8'h5a, 8'h00, 1);
   endtask
   task automatic t_page_wrap();
      wr(11'h51f, 8'h11, 8'h22, 2);
      prog();
      rd(11'h510, 8'h22, 8'h5a, 2);
      rd(11'h51f, 8'h11, 8'h00, 1);
   endtask
   task automatic t_protect();
      @(posedge clk_i);
      #1 wp_i = 1'b1;
      wr(11'h511, 8'h00, 8'h00, 1);
      repeat (200) @(posedge clk_i);
      chk({7'h00, prog_busy_o}, 8'h00);
      @(posedge clk_i);
      #1 wp_i = 1'b0;
      rd(11'h511, 8'h5a, 8'h00, 1);
   endtask
   task automatic t_bad_cmd();
      m.start();
      snd(8'h50, 1'b1);
      snd(8'ha0, 1'b1);
      m.stop();
      rd(11'h51f, 8'h11, 8'h00, 1);
   endtask
   task automatic t_rollover();
      wr(11'h7ff, 8'h3c, 8'h00, 1);
      prog();
      wr(11'h000, 8'hc3, 8'h00, 1);
      prog();
      rd(11'h7ff, 8'h3c, 8'hc3, 2);
   endtask
   initial begin
      rst_n_i = 1'b0;
      wp_i = 1'b0;
      bad_count = 0;
      cmp_count = 0;
      repeat (8) @(posedge clk_i);
      #1 rst_n_i = 1'b1;
      #1000;
      t_byte_write();
      t_page_wrap();
      t_protect();
      t_bad_cmd();
      t_rollover();
      test_done();
   end
endmodule
